/* design/bfte_exec.sv */
// Execution unit for field extract, conditional traps and local register flush.
`timescale 1ns/1ps
module bfte_exec
  import bfte_pkg::*;
#(
  parameter int NSETS = 4
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire bfte_instr_t  instr,
  input  wire logic [2:0]   arith_ctrl_cond_code,
  input  wire logic         ret_req,
  input  wire logic         call_req,
  input  wire logic [31:0]  call_frame,
  input  wire logic         lreg_we,
  input  wire logic [3:0]   lreg_idx,
  input  wire logic [31:0]  lreg_wdata,
  input  wire logic         mem_ack,
  input  wire logic [31:0]  mem_rdata,
  output bfte_result_t      result,
  output logic              trap_fault,
  output logic              done,
  output logic              busy,
  output logic              mem_req,
  output logic              mem_we,
  output logic [31:0]       mem_addr,
  output logic [31:0]       mem_wdata,
  output logic [31:0]       cur_frame
);
  localparam int SW = $clog2(NSETS);

  function automatic logic [31:0] field_mask(input logic [31:0] len);
    if (len >= 32'h0000_0020) begin
      field_mask = 32'hFFFF_FFFF;
    end else begin
      field_mask = (32'h0000_0001 << len[4:0]) - 32'h0000_0001; // RULE_03
    end
  endfunction

  function automatic int lidx(input logic [SW-1:0] s, input logic [3:0] w);
    lidx = int'(s) * LREG_COUNT + int'(w);
  endfunction

  logic [31:0]   lregs [NSETS*LREG_COUNT];
  logic [31:0]   frame_base [NSETS];
  logic [NSETS-1:0] set_valid;
  logic [SW-1:0] cur;
  logic [SW-1:0] ws;
  logic [3:0]    wi;
  logic [31:0]   pend_frame;
  bfte_state_t   state;

  wire logic        is_extract = instr.valid && !instr.is_ctrl && instr.opcode == OP_EXTRACT;
  wire logic        is_flush   = instr.valid && !instr.is_ctrl && instr.opcode == OP_FLUSH; // RULE_11
  wire logic        is_trap    = instr.valid && instr.is_ctrl && instr.opcode[7:3] == OP_TRAP_HIGH;
  wire logic [2:0]  trap_mask  = instr.opcode[2:0]; // RULE_12
  wire logic        trap_hit   = (trap_mask == MASK_UNORD) ?
                                 (arith_ctrl_cond_code == 3'h0) : // RULE_06
                                 ((trap_mask & arith_ctrl_cond_code) != 3'h0); // RULE_04 RULE_05
  wire logic [31:0] shifted    = instr.src >> instr.bitpos[4:0]; // RULE_02
  wire logic [31:0] extracted  = shifted & field_mask(instr.len); // RULE_01
  wire logic [SW-1:0] prev_set = cur - SW'(1);
  wire logic [SW-1:0] next_set = cur + SW'(1);
  wire logic [31:0] ret_frame  = lregs[lidx(cur, 4'h0)] & FRAME_ALIGN; // RULE_10
  wire logic [31:0] word_addr  = frame_base[ws] + SAVE_OFS + WORD_BYTES * {28'h0, wi};
  wire logic        last_word  = wi == 4'hF;
  wire logic        last_set   = ws == SW'(NSETS - 1);
  wire logic        word_done  = mem_req && mem_ack;
  wire logic        skip_set   = state == ST_FLUSH && !set_valid[ws] && !mem_req;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state      <= ST_IDLE;
      result     <= '0;
      trap_fault <= 1'b0;
      done       <= 1'b0;
      busy       <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 32'h0;
      mem_wdata  <= 32'h0;
      cur        <= '0;
      ws         <= '0;
      wi         <= 4'h0;
      pend_frame <= 32'h0;
      set_valid  <= '0;
    end else begin
      result.valid <= 1'b0;
      trap_fault   <= 1'b0;
      done         <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (is_extract) begin
            result.valid <= 1'b1;
            result.data  <= extracted; // RULE_01
            done         <= 1'b1;
          end else if (is_trap) begin
            trap_fault <= trap_hit; // RULE_04
            done       <= 1'b1;
          end else if (is_flush) begin
            state <= ST_FLUSH; // RULE_07
            ws    <= '0;
            wi    <= 4'h0;
            busy  <= 1'b1;
          end else if (ret_req) begin
            cur        <= prev_set;
            ws         <= prev_set;
            wi         <= 4'h0;
            pend_frame <= ret_frame; // RULE_10
            if (!set_valid[prev_set] || frame_base[prev_set] != ret_frame) begin
              state               <= ST_RELOAD; // RULE_09
              busy                <= 1'b1;
              set_valid[prev_set] <= 1'b0;
            end else begin
              done <= 1'b1;
            end
          end else if (call_req) begin
            ws         <= next_set;
            wi         <= 4'h0;
            pend_frame <= call_frame;
            if (set_valid[next_set]) begin
              state <= ST_SPILL;
              busy  <= 1'b1;
            end else begin
              cur                 <= next_set;
              set_valid[next_set] <= 1'b1;
              done                <= 1'b1;
            end
          end
        end
        ST_FLUSH, ST_SPILL, ST_RELOAD: begin
          if (skip_set) begin
            ws <= ws + SW'(1);
            if (last_set) begin
              state     <= ST_IDLE;
              busy      <= 1'b0;
              done      <= 1'b1;
              set_valid <= set_valid & (NSETS'(1) << cur); // RULE_08
            end
          end else if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= state != ST_RELOAD;
            mem_addr  <= word_addr;
            mem_wdata <= lregs[lidx(ws, wi)]; // RULE_07
          end else if (word_done) begin
            mem_req <= 1'b0;
            wi      <= wi + 4'h1;
            if (last_word) begin
              if (state == ST_FLUSH && !last_set) begin
                ws <= ws + SW'(1);
              end else begin
                state <= ST_IDLE;
                busy  <= 1'b0;
                done  <= 1'b1;
                if (state == ST_FLUSH) begin
                  set_valid <= set_valid & (NSETS'(1) << cur); // RULE_08
                end else begin
                  cur           <= ws;
                  set_valid[ws] <= 1'b1; // RULE_09
                end
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // Frame bases and register words carry no reset; validity bits guard them.
  always_ff @(posedge core_clk) begin
    if (state == ST_IDLE && call_req && !is_extract && !is_trap && !is_flush && !ret_req &&
        !set_valid[next_set]) begin
      frame_base[next_set] <= call_frame;
    end else if (state == ST_IDLE && ret_req && !is_extract && !is_trap && !is_flush) begin
      frame_base[prev_set] <= ret_frame;
    end else if (state == ST_SPILL && word_done && last_word) begin
      frame_base[ws] <= pend_frame;
    end
    if (state == ST_RELOAD && word_done) begin
      lregs[lidx(ws, wi)] <= mem_rdata; // RULE_09
    end else if (state == ST_IDLE && lreg_we) begin
      lregs[lidx(cur, lreg_idx)] <= lreg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_frame <= 32'h0;
    end else if (done) begin
      cur_frame <= frame_base[cur];
    end
  end

  // Checks on the observable behaviour.
  logic [31:0] exp_extract;
  logic        exp_fault;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      exp_extract <= 32'h0;
      exp_fault   <= 1'b0;
    end else begin
      exp_extract <= (instr.src >> (instr.bitpos % 32)) &
                     ((instr.len >= 32'h0000_0020) ? 32'hFFFF_FFFF :
                      ((32'h0000_0001 << instr.len[4:0]) - 32'h0000_0001));
      exp_fault   <= (instr.opcode[2:0] == 3'h0) ? (arith_ctrl_cond_code == 3'h0) :
                     ((instr.opcode[2:0] & arith_ctrl_cond_code) != 3'h0);
    end
  end

  a_extract_value: assert property (@(posedge core_clk) disable iff (reset) // RULE_01
    state == ST_IDLE && is_extract |=> result.valid && result.data == exp_extract)
    else $error("extract result wrong");
  a_extract_shift: assert property (@(posedge core_clk) disable iff (reset) // RULE_02
    state == ST_IDLE && is_extract && instr.len >= 32'h20 |=>
    result.data == exp_extract)
    else $error("shift amount not taken modulo 32");
  a_mask_width: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    state == ST_IDLE && is_extract && instr.len < 32'h20 |=>
    (result.data >> $past(instr.len[4:0])) == 32'h0)
    else $error("bits above field not cleared");
  a_trap_fault: assert property (@(posedge core_clk) disable iff (reset) // RULE_04
    state == ST_IDLE && is_trap && trap_mask != MASK_UNORD |=> trap_fault == exp_fault && done)
    else $error("masked trap outcome wrong");
  a_trap_unord: assert property (@(posedge core_clk) disable iff (reset) // RULE_06
    state == ST_IDLE && is_trap && trap_mask == MASK_UNORD |=>
    trap_fault == ($past(arith_ctrl_cond_code) == 3'h0))
    else $error("unordered trap outcome wrong");
  a_trap_masks: assert property (@(posedge core_clk) disable iff (reset) // RULE_05
    state == ST_IDLE && is_trap && trap_mask == MASK_LE && arith_ctrl_cond_code == MASK_GT
    |=> !trap_fault)
    else $error("less-or-equal mask fires on greater");
  a_flush_write: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    state == ST_FLUSH && mem_req |-> mem_we)
    else $error("flush issued a read");
  a_flush_inval: assert property (@(posedge core_clk) disable iff (reset) // RULE_08
    $fell(busy) && $past(state) == ST_FLUSH |-> set_valid == (NSETS'(1) << cur))
    else $error("flush left other sets valid");
  a_reload_read: assert property (@(posedge core_clk) disable iff (reset) // RULE_09
    state == ST_RELOAD && mem_req |-> !mem_we ##0 set_valid[ws] == 1'b0)
    else $error("reload not from memory");
  a_ret_target: assert property (@(posedge core_clk) disable iff (reset) // RULE_10
    state == ST_IDLE && ret_req && !instr.valid |=> pend_frame == $past(ret_frame))
    else $error("return target not from r0");
  a_flush_decode: assert property (@(posedge core_clk) disable iff (reset) // RULE_11
    state == ST_IDLE && is_flush |=> state == ST_FLUSH && busy)
    else $error("flush opcode not decoded");

  // Counts flush writes so the end of a flush can be held against the sets it found valid.
  logic [7:0] flush_words;
  logic [7:0] flush_expect;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flush_words  <= 8'h0;
      flush_expect <= 8'h0;
    end else if (state == ST_IDLE && is_flush) begin
      flush_words  <= 8'h0;
      flush_expect <= 8'($countones(set_valid) * LREG_COUNT);
    end else if (state == ST_FLUSH && word_done) begin
      flush_words <= flush_words + 8'h1;
    end
  end

  a_flush_count: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    $fell(busy) && $past(state) == ST_FLUSH |-> flush_words == flush_expect)
    else $error("flush wrote wrong number of words");
  a_flush_valid: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    state == ST_FLUSH && mem_req |-> set_valid[ws])
    else $error("flush wrote an invalid set");
  a_mem_hold: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata) &&
    $stable(mem_we))
    else $error("memory request changed before acknowledge");
  a_flush_keeps: assert property (@(posedge core_clk) disable iff (reset) // RULE_08
    state == ST_FLUSH |=> $stable(cur))
    else $error("flush moved the current set");
  a_ret_reload: assert property (@(posedge core_clk) disable iff (reset) // RULE_09
    state == ST_IDLE && ret_req && !instr.valid && !set_valid[prev_set] |=>
    state == ST_RELOAD && busy)
    else $error("return to invalid set did not reload");
  a_reload_end: assert property (@(posedge core_clk) disable iff (reset) // RULE_09
    $fell(busy) && $past(state) == ST_RELOAD |-> set_valid[cur])
    else $error("reloaded set not marked valid");
  a_extract_done: assert property (@(posedge core_clk) disable iff (reset) // RULE_01
    state == ST_IDLE && is_extract |=> done && !trap_fault)
    else $error("extract did not complete cleanly");

  c_fault_raised: cover property (@(posedge core_clk) disable iff (reset) trap_fault);
  c_flush_done: cover property (@(posedge core_clk) disable iff (reset)
    $fell(busy) && $past(state) == ST_FLUSH);
  c_reload_done: cover property (@(posedge core_clk) disable iff (reset)
    $fell(busy) && $past(state) == ST_RELOAD);
  c_spill_done: cover property (@(posedge core_clk) disable iff (reset)
    $fell(busy) && $past(state) == ST_SPILL);
  c_extract_seen: cover property (@(posedge core_clk) disable iff (reset) result.valid);
endmodule

/* inc/bfte_pkg.sv */
// Constants and types for the bit-field, conditional trap and register flush unit.
// Notes on behaviour
// [RULE_01] Field extract shifts the field down to bit zero and clears bits above it.
// [RULE_02] Only the low-bit operand modulo 32 is used as the right shift.
// [RULE_03] Shifted value is ANDed with a mask of width low-order ones.
// [RULE_04] Masked traps fault when mask AND condition code is non-zero, else no effect.
// [RULE_05] Trap masks: unordered 000 up to ordered 111, in documented order.
// [RULE_06] Unordered trap faults exactly when the whole condition code is zero.
// [RULE_07] Flush writes every cached local set back to its frame save area.
// [RULE_08] After the flush every set except the current one is invalid.
// [RULE_09] A frame made current while invalid is reloaded from memory before use.
// [RULE_10] A return goes to the frame named by the pointer in r0.
// [RULE_11] Register-format opcode 66D decodes as the operand-less flush.
// [RULE_12] The trap mask is the low three bits of the control opcode.
package bfte_pkg;
  localparam logic [11:0] OP_EXTRACT   = 12'h651;
  localparam logic [11:0] OP_FLUSH     = 12'h66D;
  localparam logic [4:0]  OP_TRAP_HIGH = 5'h03;
  localparam logic [2:0]  MASK_UNORD   = 3'h0;
  localparam logic [2:0]  MASK_GT      = 3'h1;
  localparam logic [2:0]  MASK_EQ      = 3'h2;
  localparam logic [2:0]  MASK_GE      = 3'h3;
  localparam logic [2:0]  MASK_LT      = 3'h4;
  localparam logic [2:0]  MASK_NE      = 3'h5;
  localparam logic [2:0]  MASK_LE      = 3'h6;
  localparam logic [2:0]  MASK_ORD     = 3'h7;
  localparam int          LREG_COUNT   = 16;
  localparam logic [31:0] SAVE_OFS     = 32'h0000_0000;
  localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
  localparam logic [31:0] FRAME_ALIGN  = 32'hFFFF_FFC0;

  typedef struct packed {
    logic        valid;
    logic        is_ctrl;
    logic [11:0] opcode;
    logic [31:0] bitpos;
    logic [31:0] len;
    logic [31:0] src;
  } bfte_instr_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } bfte_result_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_FLUSH  = 2'h1,
    ST_SPILL  = 2'h3,
    ST_RELOAD = 2'h2
  } bfte_state_t;
endpackage

/* tb/bfte_mem_model.sv */
// Behavioural memory holding the procedure stack frames behind the unit.
`timescale 1ns/1ps
module bfte_mem_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] store [logic [31:0]];
  logic [31:0] rnd, last_rd, a_q, d_q;
  logic        fire, we_q;
  int          rd_cnt, waited;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    rnd = 32'h5EED_0001;
    rd_cnt = 0;
    waited = 0;
    forever begin
      @(posedge core_clk);
      fire = mem_req & mem_ack;
      a_q = mem_addr;
      we_q = mem_we;
      d_q = mem_wdata;
      #1;
      // An idle data line toggles so a stale word can never pass for a fresh one.
      mem_rdata = ~mem_rdata;
      if (reset) begin
        mem_ack = 1'b0;
        waited = 0;
      end else if (fire) begin
        mem_ack = 1'b0;
        waited = 0;
        if (we_q) store[a_q] = d_q;
        else begin
          rd_cnt++;
          last_rd = a_q;
        end
      end else if (mem_req && waited >= rnd[1:0]) begin
        mem_ack = 1'b1;
        mem_rdata = store.exists(mem_addr) ? store[mem_addr] : ~mem_addr;
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      end else if (mem_req) waited++;
    end
  end
endmodule

/* tb/bitfield_trap_flush_exec_tb.sv */
// Self-checking bench for the field extract, trap and register flush unit.
`timescale 1ns/1ps
module bitfield_trap_flush_exec_tb;
  import bfte_pkg::*;
  logic         core_clk, reset, ret_req, call_req, lreg_we, mem_ack;
  logic         trap_fault, done, busy, mem_req, mem_we;
  logic [2:0]   cc, tm, tc;
  logic [3:0]   lreg_idx;
  logic [31:0]  call_frame, lreg_wdata, mem_rdata, mem_addr, mem_wdata, cur_frame;
  logic [31:0]  seed, p, n, s, base_rd, fr [4], ev [4][16];
  bfte_instr_t  instr;
  bfte_result_t result;
  bfte_result_t got_res;
  logic         got_done, got_fault, got_busy;
  int           error_cnt, checks_done;

  bfte_exec #(.NSETS(4)) i_dut (.core_clk(core_clk), .reset(reset), .instr(instr),
    .arith_ctrl_cond_code(cc), .ret_req(ret_req), .call_req(call_req),
    .call_frame(call_frame), .lreg_we(lreg_we), .lreg_idx(lreg_idx),
    .lreg_wdata(lreg_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .result(result),
    .trap_fault(trap_fault), .done(done), .busy(busy), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .cur_frame(cur_frame));
  bfte_mem_model i_mem (.core_clk(core_clk), .reset(reset), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] ext_exp(input logic [31:0] v, bp, ln);
    logic [31:0] m;
    m = (ln >= 32) ? 32'hFFFF_FFFF : ((32'h1 << ln) - 32'h1);
    return (v >> bp[4:0]) & m;
  endfunction
  function automatic logic trap_exp(input logic [2:0] m, c);
    return (m == 3'h0) ? (c == 3'h0) : ((m & c) != 3'h0);
  endfunction

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic issue(input logic ctl, input logic [11:0] op, input logic [31:0] a, b, d);
    instr = '{1'b1, ctl, op, a, b, d};
    tick();
    // The answer pulses stand for this one cycle only, so they are taken here.
    got_res = result;
    got_done = done;
    got_fault = trap_fault;
    got_busy = busy;
    instr.valid = 1'b0;
    tick();
  endtask
  task automatic wait_done();
    for (int i = 0; i < 600 && done !== 1'b1; i++) tick();
    chk("done", 32'(done), 32'h1);
  endtask
  task automatic wait_idle();
    tick();
    tick();
    for (int i = 0; i < 600 && busy === 1'b1; i++) tick();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // The slowest path is a few hundred cycles; this limit leaves ample margin.
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end

  initial begin
    {ret_req, call_req, lreg_we, lreg_idx, lreg_wdata, call_frame, cc} = '0;
    instr = '0;
    seed = 32'hA2F3_EED1;
    reset = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      p = (k == 0) ? 32'h25 : {24'h0, seed[7:0]};
      n = (k == 1) ? 32'h0 : (k == 2) ? 32'h20 : {26'h0, seed[13:8]};
      seed = lfsr(seed);
      s = seed;
      issue(1'b0, OP_EXTRACT, p, n, s);
      chk("ext_valid", 32'(got_res.valid), 32'h1);
      chk("ext_data", got_res.data, ext_exp(s, p, n));
    end
    $display("extract test done");
    for (int k = 0; k < 64; k++) begin
      {tm, tc} = 6'(k);
      cc = tc;
      issue(1'b1, {4'h0, OP_TRAP_HIGH, tm}, 32'h0, 32'h0, 32'h0);
      chk("trap_done", 32'(got_done), 32'h1);
      chk("trap_fault", 32'(got_fault), 32'(trap_exp(tm, tc)));
    end
    $display("trap test done");
    fr[0] = 32'h0;
    for (int k = 1; k < 4; k++) begin
      fr[k] = 32'h1000 * k;
      call_frame = fr[k];
      call_req = 1'b1;
      tick();
      call_req = 1'b0;
      wait_idle();
      lreg_we = 1'b1;
      for (int w = 0; w < 16; w++) begin
        seed = lfsr(seed);
        ev[k][w] = (w == 0) ? fr[k-1] : seed;
        lreg_idx = 4'(w);
        lreg_wdata = ev[k][w];
        tick();
      end
      lreg_we = 1'b0;
    end
    issue(1'b0, OP_FLUSH, 32'h0, 32'h0, 32'h0);
    chk("flush_busy", 32'(got_busy), 32'h1);
    wait_done();
    // The last word lands in the model just after the edge that shows done.
    tick();
    for (int k = 1; k < 4; k++)
      for (int w = 0; w < 16; w++)
        chk("saved_word", i_mem.store[fr[k] + 4 * w], ev[k][w]);
    $display("flush test done");
    // Rewriting r0 after the flush must send the return two frames back.
    lreg_we = 1'b1;
    lreg_idx = 4'h0;
    lreg_wdata = fr[1];
    tick();
    lreg_we = 1'b0;
    base_rd = 32'(i_mem.rd_cnt);
    ret_req = 1'b1;
    tick();
    ret_req = 1'b0;
    wait_done();
    tick();
    chk("ret_frame", cur_frame, fr[1]);
    chk("reload_cnt", 32'(i_mem.rd_cnt) - base_rd, 32'h10);
    chk("reload_last", i_mem.last_rd, fr[1] + 32'h3C);
    $display("return test done");
    // A call into the still-valid old current set must spill it to its own frame first.
    call_frame = 32'h4000;
    call_req = 1'b1;
    tick();
    call_req = 1'b0;
    wait_done();
    tick();
    chk("call_frame", cur_frame, 32'h4000);
    for (int w = 0; w < 16; w++) begin
      s = (w == 0) ? fr[1] : ev[3][w];
      chk("spill_word", i_mem.store[fr[3] + 4 * w], s);
    end
    $display("spill test done");
    finish_test();
  end
endmodule
